/* File: logic/fifo_port_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fifo_port_if;
   import mmfifo_pkg::*;
   logic                push;
   logic [SAMPLE_W-1:0] push_data;
   logic                pop;
   logic [SAMPLE_W-1:0] head;
   logic                full;
   logic                empty;
   logic [CNT_W-1:0]    level;
   modport owner (input push, push_data, pop,
                  output head, full, empty, level);
   modport user  (output push, push_data, pop,
                  input head, full, empty, level);
endinterface
`default_nettype wire

/* File: logic/mm_fifo_pair.sv */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mm_fifo_pair
   import mmfifo_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   // user push into read side
   input  wire logic [SAMPLE_W-1:0] user_sample,
   input  wire logic                sample_qualifier,
   output var  logic                ready,
   // read side bus observation
   output var  logic [SAMPLE_W-1:0] bus_side_sample,
   output var  logic                bus_side_sample_flag,
   // write side downstream
   input  wire logic                downstream_ready,
   output var  logic [SAMPLE_W-1:0] drained_sample,
   output var  logic                drained_sample_flag,
   // axi4-lite slave
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   // =========================================================
   // parameter checks
   if (FIFO_DEPTH <= 2)
   begin : g_depth_chk
      $error("fifo depth must exceed two");
   end
   if (INT_BITS < 0)
   begin : g_int_chk
      $error("integer width must not be negative");
   end
   if (FRAC_BITS < 0)
   begin : g_frac_chk
      $error("fraction width must not be negative");
   end
   if (SAMPLE_W < 1)
   begin : g_width_chk
      $error("sample must hold at least one bit");
   end
   if (SAMPLE_W > 32)
   begin : g_word_chk
      $error("sample must fit one bus word");
   end

   // =========================================================
   // state
   typedef struct packed
   {
      logic                awdone;
      logic [7:0]          awaddr;
      logic                wdone;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic [1:0]          ctrl;
      logic                ready;
      logic [SAMPLE_W-1:0] bus_sample;
      logic                bus_flag;
      logic [SAMPLE_W-1:0] drn_sample;
      logic                drn_flag;
      logic                awready;
      logic                wready;
      logic                arready;
   } top_state_t;

   top_state_t st_ff;
   top_state_t nxt_st;

   fifo_port_if rd_q ();
   fifo_port_if wr_q ();

   sample_fifo u_rd_fifo
   (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (rd_q.owner)
   );

   sample_fifo u_wr_fifo
   (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (wr_q.owner)
   );

   // sign or zero extension of a sample to a bus word
   function automatic logic [31:0] widen(input logic [SAMPLE_W-1:0] s);
      logic [31:0] w;
      w = '0;
      if (SAMPLE_FMT == FMT_UNSIGNED || SAMPLE_W == 1)
         w = 32'(s);
      else
         w = 32'(signed'(s));
      widen = w;
   endfunction

   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] r);
      is_addr = (a[7:2] == r[7:2]);
   endfunction

   logic             wr_go;
   logic             rd_go;
   logic             rd_stall;
   logic             wr_stall;
   logic [31:0]      status_word;
   logic [CNT_W-1:0] rd_next_level;

   // =========================================================
   // next state
   always_comb
   begin
      nxt_st       = st_ff;
      rd_stall     = st_ff.ctrl[CTL_RD_STALL];
      wr_stall     = st_ff.ctrl[CTL_WR_STALL];
      status_word  = '0;
      status_word[ST_RD_LEVEL +: CNT_W] = rd_q.level;
      status_word[ST_WR_LEVEL +: CNT_W] = wr_q.level;
      status_word[ST_RD_FULL]           = rd_q.full;
      status_word[ST_WR_FULL]           = wr_q.full;
      status_word[ST_RD_EMPTY]          = rd_q.empty;

      // =========================================================
      // user side push into read fifo
      rd_q.push      = sample_qualifier && st_ff.ready;
      rd_q.push_data = user_sample;

      // =========================================================
      // write channel capture
      if (s_axi_awvalid && !st_ff.awdone)
      begin
         nxt_st.awdone = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.wdone)
      begin
         nxt_st.wdone = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      wr_go          = st_ff.awdone && st_ff.wdone && !st_ff.bvalid;
      wr_q.push      = 1'b0;
      wr_q.push_data = st_ff.wdata[SAMPLE_W-1:0];
      if (wr_go)
      begin
         nxt_st.awdone = 1'b0;
         nxt_st.wdone  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = RESP_OKAY;
         if (is_addr(st_ff.awaddr, ADDR_WR_DATA))
         begin
            if (wr_q.full)
               nxt_st.bresp = RESP_SLVERR;
            else
               wr_q.push = 1'b1;
         end
         else if (is_addr(st_ff.awaddr, ADDR_CONTROL))
         begin
            if (st_ff.wstrb[0])
               nxt_st.ctrl = st_ff.wdata[1:0];
         end
         else if (!is_addr(st_ff.awaddr, ADDR_STATUS) &&
                  !is_addr(st_ff.awaddr, ADDR_RD_DATA))
            nxt_st.bresp = RESP_SLVERR;
      end
      if (st_ff.bvalid && s_axi_bready)
         nxt_st.bvalid = 1'b0;

      // =========================================================
      // read channel
      rd_go     = s_axi_arvalid && !st_ff.rvalid;
      rd_q.pop  = 1'b0;
      nxt_st.bus_flag = 1'b0;
      if (rd_go)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = RESP_OKAY;
         nxt_st.rdata  = '0;
         if (is_addr(s_axi_araddr, ADDR_RD_DATA))
         begin
            if (rd_stall || rd_q.empty)
            begin
               nxt_st.rdata = RD_EMPTY_WORD;
               nxt_st.rresp = RESP_SLVERR;
            end
            else
            begin
               rd_q.pop          = 1'b1;
               nxt_st.rdata      = widen(rd_q.head);
               nxt_st.bus_sample = rd_q.head;
               nxt_st.bus_flag   = 1'b1;
            end
         end
         else if (is_addr(s_axi_araddr, ADDR_STATUS))
            nxt_st.rdata = status_word;
         else if (is_addr(s_axi_araddr, ADDR_CONTROL))
            nxt_st.rdata = 32'(st_ff.ctrl);
         else if (!is_addr(s_axi_araddr, ADDR_WR_DATA))
            nxt_st.rresp = RESP_SLVERR;
      end
      if (st_ff.rvalid && s_axi_rready)
         nxt_st.rvalid = 1'b0;

      // ready for next cycle from next occupancy
      rd_next_level = rd_q.level;
      if (rd_q.push && !rd_q.pop)
         rd_next_level = rd_q.level + 1'b1;
      else if (rd_q.pop && !rd_q.push)
         rd_next_level = rd_q.level - 1'b1;
      nxt_st.ready = (rd_next_level != CNT_W'(FIFO_DEPTH));

      // =========================================================
      // write side drain toward downstream
      wr_q.pop        = 1'b0;
      nxt_st.drn_flag = 1'b0;
      if (downstream_ready && !wr_stall && !wr_q.empty)
      begin
         wr_q.pop          = 1'b1;
         nxt_st.drn_sample = wr_q.head;
         nxt_st.drn_flag   = 1'b1;
      end

      // handshake readies held in flops so each output is registered
      nxt_st.awready = !nxt_st.awdone;
      nxt_st.wready  = !nxt_st.wdone;
      nxt_st.arready = !nxt_st.rvalid;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff       <= '0;
         st_ff.ready <= 1'b1;
         st_ff.ctrl  <= CTL_RESET;
         st_ff.awready <= 1'b1;
         st_ff.wready  <= 1'b1;
         st_ff.arready <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   // =========================================================
   // outputs
   assign ready                = st_ff.ready;
   assign bus_side_sample      = st_ff.bus_sample;
   assign bus_side_sample_flag = st_ff.bus_flag;
   assign drained_sample       = st_ff.drn_sample;
   assign drained_sample_flag  = st_ff.drn_flag;
   assign s_axi_awready        = st_ff.awready;
   assign s_axi_wready         = st_ff.wready;
   assign s_axi_bvalid         = st_ff.bvalid;
   assign s_axi_bresp          = st_ff.bresp;
   assign s_axi_arready        = st_ff.arready;
   assign s_axi_rvalid         = st_ff.rvalid;
   assign s_axi_rdata          = st_ff.rdata;
   assign s_axi_rresp          = st_ff.rresp;
endmodule
`default_nettype wire

/* File: logic/mmfifo_pkg.sv */
package mmfifo_pkg;
   // =========================================================
   // sample format
   typedef enum logic [1:0]
   {
      FMT_SIGNED_INT  = 2'h0,
      FMT_SIGNED_FRAC = 2'h1,
      FMT_UNSIGNED    = 2'h2
   } sample_fmt_t;

   localparam int          INT_BITS    = 16;
   localparam int          FRAC_BITS   = 0;
   localparam sample_fmt_t SAMPLE_FMT  = FMT_SIGNED_INT;
   localparam int          SAMPLE_W    = (SAMPLE_FMT == FMT_SIGNED_FRAC)
                                         ? INT_BITS + FRAC_BITS : INT_BITS;
   localparam int          FIFO_DEPTH  = 8;
   localparam int          PTR_W       = $clog2(FIFO_DEPTH);
   localparam int          CNT_W       = $clog2(FIFO_DEPTH + 1);

   // =========================================================
   // register map, byte addresses
   localparam logic [7:0]  ADDR_RD_DATA   = 8'h00;
   localparam logic [7:0]  ADDR_WR_DATA   = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_CONTROL   = 8'h0C;
   localparam int          ST_RD_LEVEL    = 0;
   localparam int          ST_WR_LEVEL    = 8;
   localparam int          ST_RD_FULL     = 16;
   localparam int          ST_WR_FULL     = 17;
   localparam int          ST_RD_EMPTY    = 18;
   localparam int          CTL_RD_STALL   = 0;
   localparam int          CTL_WR_STALL   = 1;
   localparam logic [1:0]  CTL_RESET      = 2'h0;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [31:0] RD_EMPTY_WORD  = 32'h0000_0000;
endpackage

/* File: logic/sample_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module sample_fifo
   import mmfifo_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   fifo_port_if.owner  port
);
   // =========================================================
   // state
   typedef struct packed
   {
      logic [FIFO_DEPTH-1:0][SAMPLE_W-1:0] mem;
      logic [PTR_W-1:0]                    wr_ptr;
      logic [PTR_W-1:0]                    rd_ptr;
      logic [CNT_W-1:0]                    count;
   } fifo_state_t;

   fifo_state_t st_ff;
   fifo_state_t nxt_st;
   logic        do_push;
   logic        do_pop;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // =========================================================
   // next state
   always_comb
   begin
      nxt_st  = st_ff;
      do_push = port.push && (st_ff.count != CNT_W'(FIFO_DEPTH));
      do_pop  = port.pop && (st_ff.count != '0);
      if (do_push)
      begin
         nxt_st.mem[st_ff.wr_ptr] = port.push_data;
         nxt_st.wr_ptr            = ptr_inc(st_ff.wr_ptr);
      end
      if (do_pop)
         nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
      if (do_push && !do_pop)
         nxt_st.count = st_ff.count + 1'b1;
      else if (do_pop && !do_push)
         nxt_st.count = st_ff.count - 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign port.head  = st_ff.mem[st_ff.rd_ptr];
   assign port.full  = (st_ff.count == CNT_W'(FIFO_DEPTH));
   assign port.empty = (st_ff.count == '0);
   assign port.level = st_ff.count;
endmodule
`default_nettype wire

/* File: test/mm_fifo_pair_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module mm_fifo_pair_asserts
   import mmfifo_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                sample_qualifier,
   input wire logic                ready,
   input wire logic [SAMPLE_W-1:0] bus_side_sample,
   input wire logic                bus_side_sample_flag,
   input wire logic                downstream_ready,
   input wire logic [SAMPLE_W-1:0] drained_sample,
   input wire logic                drained_sample_flag,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid
);
   logic [CNT_W-1:0] lvl_ff;
   logic [CNT_W-1:0] nxt_lvl;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // read-side level, pops counted at the flag
   always_comb
      nxt_lvl = lvl_ff + CNT_W'(sample_qualifier && ready)
              - CNT_W'(bus_side_sample_flag);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         lvl_ff <= '0;
      else
         lvl_ff <= nxt_lvl;
   ready_full_a:
      assert property (!bus_side_sample_flag && lvl_ff == FIFO_DEPTH
         |-> !ready) else $error("ready high with full buffer");
   ready_room_a:
      assert property (!bus_side_sample_flag && lvl_ff < FIFO_DEPTH
         |-> ready) else $error("ready low with room");
   rd_pulse_a:
      assert property (bus_side_sample_flag |=> !bus_side_sample_flag)
         else $error("read flag longer than one cycle");
   rd_match_a:
      assert property (bus_side_sample_flag |-> s_axi_rvalid
         && s_axi_rresp == RESP_OKAY
         && s_axi_rdata[SAMPLE_W-1:0] == bus_side_sample)
         else $error("read flag without matching bus data");
   empty_quiet_a:
      assert property (lvl_ff == 0 && !bus_side_sample_flag
         |=> !bus_side_sample_flag) else $error("pop from empty");
   drain_cause_a:
      assert property (drained_sample_flag |-> $past(downstream_ready))
         else $error("drain without downstream ready");
   drain_hold_a:
      assert property (!drained_sample_flag |-> $stable(drained_sample))
         else $error("drained sample moved without flag");
   reset_state_a:
      assert property ($rose(rst_n) |-> ready && !bus_side_sample_flag
         && !drained_sample_flag) else $error("bad state after reset");
endmodule
bind mm_fifo_pair mm_fifo_pair_asserts chk_u
   (.clk, .rst_n, .sample_qualifier, .ready, .bus_side_sample,
    .bus_side_sample_flag, .downstream_ready, .drained_sample,
    .drained_sample_flag, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

/* File: test/mm_fifo_pair_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module mm_fifo_pair_tb
   import mmfifo_pkg::*;
   ;
   localparam logic [SAMPLE_W-1:0] BASE = 16'h8001;
   logic clk = 0, rst_n = 0, src_en = 0, downstream_ready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, sample_qualifier, ready;
   logic bus_side_sample_flag, drained_sample_flag;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [SAMPLE_W-1:0] user_sample, bus_side_sample, drained_sample;
   logic [SAMPLE_W-1:0] drq[$];
   int n_errors = 0, comparisons = 0, cyc = 0;
   mm_fifo_pair dut_u (.clk, .rst_n, .user_sample, .sample_qualifier,
      .ready, .bus_side_sample, .bus_side_sample_flag, .downstream_ready,
      .drained_sample, .drained_sample_flag, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   user_src #(.BASE(BASE)) src_u (.clk, .rst_n, .en(src_en), .ready,
      .sample(user_sample), .qual(sample_qualifier));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (drained_sample_flag)
         drq.push_back(drained_sample);
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         results();
      end
   end
   // ==========================================
   // checking and bus tasks
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, er);
   endtask
   task automatic rd(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      check("rresp", s_axi_rresp, er);
   endtask
   // ==========================================
   // scenarios
   task automatic t_fill();
      logic [31:0] d;
      int n;
      wr(ADDR_CONTROL, 32'h0000_0001, RESP_OKAY);
      src_en <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (ready && n < 100);
      src_en <= 1'b0;
      check("ready full", ready, 0);
      rd(ADDR_RD_DATA, RESP_SLVERR, d);
      check("stall flag", bus_side_sample_flag, 0);
      rd(ADDR_STATUS, RESP_OKAY, d);
      check("full bit", d[ST_RD_FULL], 1);
      check("rd level", d[ST_RD_LEVEL +: 8], FIFO_DEPTH);
      $display("test fill done");
   endtask
   task automatic t_drain();
      logic [31:0] d;
      logic [SAMPLE_W-1:0] e;
      e = BASE;
      wr(ADDR_CONTROL, 0, RESP_OKAY);
      repeat (FIFO_DEPTH)
      begin
         rd(ADDR_RD_DATA, RESP_OKAY, d);
         check("rd data", d, 32'(signed'(e)));
         check("bus sample", bus_side_sample, e);
         check("bus flag", bus_side_sample_flag, 1);
         e++;
      end
      rd(ADDR_RD_DATA, RESP_SLVERR, d);
      check("empty data", d, RD_EMPTY_WORD);
      check("empty flag", bus_side_sample_flag, 0);
      check("ready room", ready, 1);
      $display("test drain done");
   endtask
   task automatic t_wr();
      wr(ADDR_CONTROL, 32'h0000_0002, RESP_OKAY);
      downstream_ready <= 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++)
         wr(ADDR_WR_DATA, 32'h0000_7FF0 + i, RESP_OKAY);
      wr(ADDR_WR_DATA, 32'h0000_1234, RESP_SLVERR);
      wr(8'h10, 0, RESP_SLVERR);
      check("stall hold", drq.size(), 0);
      downstream_ready <= 1'b0;
      wr(ADDR_CONTROL, 0, RESP_OKAY);
      repeat (4) @(posedge clk);
      check("no ready", drq.size(), 0);
      downstream_ready <= 1'b1;
      repeat (FIFO_DEPTH + 3) @(posedge clk);
      check("drain count", drq.size(), FIFO_DEPTH);
      for (int i = 0; i < FIFO_DEPTH; i++)
         check("drained", drq[i], 16'h7FF0 + i);
      $display("test write side done");
   endtask
   initial
   begin
      logic [31:0] d;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("ready", ready, 1);
      check("wr flag", drained_sample_flag, 0);
      check("rd flag", bus_side_sample_flag, 0);
      rd(ADDR_STATUS, RESP_OKAY, d);
      check("rd empty", d[ST_RD_EMPTY], 1);
      check("wr level", d[ST_WR_LEVEL +: 8], 0);
      t_fill();
      t_drain();
      t_wr();
      results();
   end
endmodule
`default_nettype wire

/* File: test/user_src.sv */
`timescale 1ns/100ps
`default_nettype none
module user_src
   import mmfifo_pkg::*;
#(
   parameter logic [SAMPLE_W-1:0] BASE = 16'h8001
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                en,
   input  wire logic                ready,
   output var  logic [SAMPLE_W-1:0] sample,
   output var  logic                qual
);
   logic [SAMPLE_W-1:0] val_ff;
   logic                q_ff;
   // ==========================================
   // counting source, holds each sample until taken
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         val_ff <= BASE;
         q_ff   <= 1'b0;
      end
      else
      begin
         if (q_ff && ready)
            val_ff <= val_ff + 1'b1;
         q_ff <= en;
      end
   end
   // junk on the data lines while not qualified
   assign qual   = q_ff;
   assign sample = q_ff ? val_ff : ~val_ff;
endmodule
`default_nettype wire
